// ---- rtl/ttpf_top.sv ----
// Overview of operation
// - pll control writes take effect only with protection clear and pll clock selected.
// - an accepted pll control write clears the lock flag and the oscillator-up flag.
// - bits 5:4 of pll control enable vco modulation whose rate is the reference over 16.
// - modulation code 00 is off, 01 is 1 percent, 10 is 2 percent, 11 is 4 percent swing.
// - the tick timer counts the internal rc clock or the oscillator clock per source select.
// - in stop the tick counter runs only with pseudo halt and oscillator source, else halts.
// - the tick control register is readable and writable at any time.
// - every write to tick control restarts the time-out period.
// - a change of tick source select, written or by oscillator loss, restarts the period.
// - tick control bit 7 picks binary (0) or decimal (1) prescale values.
// - binary prescale code 000 is off and 001 to 111 divide by 2^10 to 2^16.
// - the modulus field multiplies the prescale period by its value plus one.
// - reset leaves binary mode with prescale 000, so the timer is off.
`include "ttpf_defs.svh"

module ttpf_top (
	// clock and reset
	input  wire logic               CLK_I,
	input  wire logic               RESET_I,
	// apb slave
	input  wire logic               PSEL_I,
	input  wire logic               PENABLE_I,
	input  wire logic               PWRITE_I,
	input  wire ttpf_pkg::ttpf_addr_t PADDR_I,
	input  wire ttpf_pkg::ttpf_word_t PWDATA_I,
	output ttpf_pkg::ttpf_word_t      PRDATA_O,
	output logic                    PREADY_O,
	output logic                    PSLVERR_O,
	// asynchronous pins
	input  wire logic               IRC_CLK_I,
	input  wire logic               OSC_CLK_I,
	input  wire logic               FREF_I,
	input  wire logic               STOP_I,
	input  wire logic               PLL_LOCK_I,
	input  wire logic               OSC_GOOD_I,
	// results
	output logic                    IRQ_O,
	output logic                    TICK_O,
	output logic [1:0]              FM_AMP_O,
	output logic                    FM_ACTIVE_O,
	output logic [3:0]              FM_PHASE_O
);
	import ttpf_pkg::*;

	ttpf_tick_if tif ();

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ttpf_pins_t  sync1;
	ttpf_pins_t  sync2;
	ttpf_pins_t  sync3;
	logic [1:0]  fm;
	ttpf_byte_t  tick_ctl;
	logic        pll_sel;
	logic        pseudo;
	logic        tsrc;
	logic        write_protect_bit;
	logic [1:0]  stat;
	logic [1:0]  mask;
	logic        lock_flag;
	logic        osc_flag;
	ttpf_word_t  rdata;
	logic [3:0]  fm_phase;
	logic        fm_active;

	logic [1:0]  next_fm;
	ttpf_byte_t  next_tick_ctl;
	logic        next_pll_sel;
	logic        next_pseudo;
	logic        next_tsrc;
	logic        next_write_protect_bit;
	logic [1:0]  next_stat;
	logic [1:0]  next_mask;
	logic        next_lock_flag;
	logic        next_osc_flag;
	ttpf_word_t  next_rdata;
	logic [3:0]  next_fm_phase;
	logic        next_fm_active;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	logic        wr;
	logic        setup_rd;
	logic        pll_accept;
	logic        tick_wr;
	logic        any_hit;
	logic        irc_rise;
	logic        osc_rise;
	logic        fref_rise;
	logic        lock_rise;
	logic        oscgood_rise;
	logic        oscgood_fall;
	logic        stop_s;
	logic        run;
	logic [1:0]  w1c;
	logic [1:0]  events;

	function automatic logic reg_hit(input ttpf_addr_t a, input ttpf_byte_t idx);
		reg_hit = (a[11:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= {IRC_CLK_I, OSC_CLK_I, FREF_I, STOP_I, PLL_LOCK_I, OSC_GOOD_I};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	assign irc_rise     = sync2[`TTPF_PIN_IRC] & ~sync3[`TTPF_PIN_IRC];
	assign osc_rise     = sync2[`TTPF_PIN_OSC] & ~sync3[`TTPF_PIN_OSC];
	assign fref_rise    = sync2[`TTPF_PIN_FREF] & ~sync3[`TTPF_PIN_FREF];
	assign lock_rise    = sync2[`TTPF_PIN_LOCK] & ~sync3[`TTPF_PIN_LOCK];
	assign oscgood_rise = sync2[`TTPF_PIN_OSCGOOD] & ~sync3[`TTPF_PIN_OSCGOOD];
	assign oscgood_fall = ~sync2[`TTPF_PIN_OSCGOOD] & sync3[`TTPF_PIN_OSCGOOD];
	assign stop_s       = sync2[`TTPF_PIN_STOP];

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign wr       = PSEL_I & PENABLE_I & PWRITE_I;
	assign setup_rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;
	assign any_hit  = reg_hit(PADDR_I, `TTPF_IDX_PLL) | reg_hit(PADDR_I, `TTPF_IDX_TICK)
		| reg_hit(PADDR_I, `TTPF_IDX_CLKSEL) | reg_hit(PADDR_I, `TTPF_IDX_WRITE_PROTECT_BIT)
		| reg_hit(PADDR_I, `TTPF_IDX_STAT) | reg_hit(PADDR_I, `TTPF_IDX_MASK);
	assign pll_accept = wr & reg_hit(PADDR_I, `TTPF_IDX_PLL) & ~write_protect_bit & pll_sel;
	assign tick_wr    = wr & reg_hit(PADDR_I, `TTPF_IDX_TICK);
	assign w1c = (wr & reg_hit(PADDR_I, `TTPF_IDX_STAT)) ? PWDATA_I[1:0] : 2'h0;

	// ----------------------------------------------------------------
	// next register values
	// ----------------------------------------------------------------
	always_comb begin
		next_fm        = fm;
		next_tick_ctl  = tick_ctl;
		next_pll_sel   = pll_sel;
		next_pseudo    = pseudo;
		next_tsrc      = tsrc;
		next_write_protect_bit      = write_protect_bit;
		next_mask      = mask;
		next_rdata     = rdata;
		events         = 2'h0;

		if (pll_accept) begin
			next_fm = PWDATA_I[`TTPF_FM_HI:`TTPF_FM_LO];
		end
		if (tick_wr) begin
			next_tick_ctl = PWDATA_I[7:0];
		end
		if (wr && reg_hit(PADDR_I, `TTPF_IDX_CLKSEL)) begin
			next_pll_sel = PWDATA_I[`TTPF_CLK_PLL_AS_SYSTEM_CLOCK_SEL];
			next_pseudo  = PWDATA_I[`TTPF_CLK_PSEUDO_HALT_SEL];
			next_tsrc    = PWDATA_I[`TTPF_CLK_TSRC] & osc_flag;
		end
		if (!osc_flag) begin
			next_tsrc = 1'b0;
		end
		if (wr && reg_hit(PADDR_I, `TTPF_IDX_WRITE_PROTECT_BIT)) begin
			next_write_protect_bit = PWDATA_I[`TTPF_WRITE_PROTECT_BIT_BIT];
		end
		if (wr && reg_hit(PADDR_I, `TTPF_IDX_MASK)) begin
			next_mask = PWDATA_I[1:0];
		end

		// status flags: a new edge wins over the clear of a pll write
		next_lock_flag = (lock_flag & ~pll_accept) | lock_rise;
		next_osc_flag  = (osc_flag & ~pll_accept & ~oscgood_fall) | oscgood_rise;

		events[`TTPF_ST_TICK]    = tif.tick;
		events[`TTPF_ST_OSCLOST] = osc_flag & oscgood_fall;
		next_stat = (stat & ~w1c) | events;

		// read data is fetched in the setup phase
		if (setup_rd) begin
			next_rdata = '0;
			unique case (1'b1)
				reg_hit(PADDR_I, `TTPF_IDX_PLL):
					next_rdata[`TTPF_FM_HI:`TTPF_FM_LO] = fm;
				reg_hit(PADDR_I, `TTPF_IDX_TICK):
					next_rdata[7:0] = tick_ctl;
				reg_hit(PADDR_I, `TTPF_IDX_CLKSEL): begin
					next_rdata[`TTPF_CLK_PLL_AS_SYSTEM_CLOCK_SEL] = pll_sel;
					next_rdata[`TTPF_CLK_PSEUDO_HALT_SEL]   = pseudo;
					next_rdata[`TTPF_CLK_TSRC]   = tsrc;
				end
				reg_hit(PADDR_I, `TTPF_IDX_WRITE_PROTECT_BIT):
					next_rdata[`TTPF_WRITE_PROTECT_BIT_BIT] = write_protect_bit;
				reg_hit(PADDR_I, `TTPF_IDX_STAT): begin
					next_rdata[1:0]           = stat;
					next_rdata[`TTPF_ST_LOCK] = lock_flag;
					next_rdata[`TTPF_ST_OSCUP] = osc_flag;
				end
				reg_hit(PADDR_I, `TTPF_IDX_MASK):
					next_rdata[1:0] = mask;
				default:
					next_rdata = '0;
			endcase
		end

		// modulation phase advances once per reference edge
		next_fm_active = (next_fm != 2'h0);
		next_fm_phase  = fm_phase;
		if (!next_fm_active) begin
			next_fm_phase = 4'h0;
		end else if (fref_rise) begin
			next_fm_phase = fm_phase + 4'h1;
		end
	end

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			fm        <= `TTPF_RST_FM;
			tick_ctl  <= `TTPF_RST_TICK;
			pll_sel   <= `TTPF_RST_PLL_AS_SYSTEM_CLOCK_SEL;
			pseudo    <= 1'b0;
			tsrc      <= 1'b0;
			write_protect_bit      <= 1'b0;
			stat      <= 2'h0;
			mask      <= `TTPF_RST_MASK;
			lock_flag <= 1'b0;
			osc_flag  <= 1'b0;
			rdata     <= '0;
			fm_phase  <= 4'h0;
			fm_active <= 1'b0;
		end else begin
			fm        <= next_fm;
			tick_ctl  <= next_tick_ctl;
			pll_sel   <= next_pll_sel;
			pseudo    <= next_pseudo;
			tsrc      <= next_tsrc;
			write_protect_bit      <= next_write_protect_bit;
			stat      <= next_stat;
			mask      <= next_mask;
			lock_flag <= next_lock_flag;
			osc_flag  <= next_osc_flag;
			rdata     <= next_rdata;
			fm_phase  <= next_fm_phase;
			fm_active <= next_fm_active;
		end
	end

	// ----------------------------------------------------------------
	// tick divider
	// ----------------------------------------------------------------
	assign run         = ~stop_s | (pseudo & tsrc);
	assign tif.cfg     = tick_ctl;
	assign tif.restart = tick_wr | (next_tsrc != tsrc);
	assign tif.step    = run & (tsrc ? osc_rise : irc_rise);

	ttpf_tick_div u_div (
		.clk_i   (CLK_I),
		.reset_i (RESET_I),
		.tif     (tif.div)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign PRDATA_O    = rdata;
	assign PREADY_O    = 1'b1;
	assign PSLVERR_O   = PSEL_I & PENABLE_I & ~any_hit;
	assign IRQ_O       = |(stat & mask);
	assign TICK_O      = tif.tick;
	assign FM_AMP_O    = fm;
	assign FM_ACTIVE_O = fm_active;
	assign FM_PHASE_O  = fm_phase;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RESET_I);

	pll_write_gate_a: assert property (
		(fm != $past(fm)) |-> $past(pll_accept))
		else $error("pll control changed without a qualified write");

	pll_flag_clear_a: assert property (
		(pll_accept && !lock_rise && !oscgood_rise) |=> (!lock_flag && !osc_flag))
		else $error("pll write did not clear the status flags");

	fm_rate_a: assert property (
		(fm_active && next_fm_active && fref_rise && fm_phase == `TTPF_FM_LAST)
		|=> (fm_phase == 4'h0 && fm_active))
		else $error("modulation phase did not wrap after sixteen reference edges");

	fm_off_a: assert property (
		(fm == 2'h0) |-> (!fm_active && fm_phase == 4'h0) or $past(pll_accept))
		else $error("modulation active while the amplitude code is off");

	src_sel_a: assert property (
		tif.step |-> ((tsrc && osc_rise) || (!tsrc && irc_rise)))
		else $error("tick counted on the unselected source");

	stop_halt_a: assert property (
		(stop_s && !(pseudo && tsrc)) |-> !tif.step)
		else $error("tick counter ran in stop without pseudo halt and oscillator");

	tick_wr_restart_a: assert property (
		tick_wr |-> tif.restart ##1 !TICK_O)
		else $error("tick control write did not restart the period");

	src_restart_a: assert property (
		(tsrc != $past(tsrc)) |-> $past(tif.restart))
		else $error("source change did not restart the period");

	osc_loss_a: assert property (
		(!osc_flag) |=> !tsrc)
		else $error("oscillator source kept after losing oscillator status");

	tick_status_a: assert property (
		TICK_O |=> stat[`TTPF_ST_TICK])
		else $error("tick did not set its status flag");
endmodule

// ---- rtl/ttpf_defs.svh ----
`ifndef TTPF_DEFS_SVH
`define TTPF_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TTPF_IDX_PLL      8'h3a
`define TTPF_IDX_TICK     8'h3b
`define TTPF_IDX_CLKSEL   8'h40
`define TTPF_IDX_WRITE_PROTECT_BIT     8'h41
`define TTPF_IDX_STAT     8'h42
`define TTPF_IDX_MASK     8'h43

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TTPF_FM_HI        5
`define TTPF_FM_LO        4
`define TTPF_TICK_DEC     7
`define TTPF_PRE_HI       6
`define TTPF_PRE_LO       4
`define TTPF_MOD_HI       3
`define TTPF_MOD_LO       0
`define TTPF_CLK_PLL_AS_SYSTEM_CLOCK_SEL   7
`define TTPF_CLK_PSEUDO_HALT_SEL     6
`define TTPF_CLK_TSRC     1
`define TTPF_WRITE_PROTECT_BIT_BIT     0
`define TTPF_ST_TICK      0
`define TTPF_ST_OSCLOST   1
`define TTPF_ST_LOCK      2
`define TTPF_ST_OSCUP     3

// ----------------------------------------------------------------
// pin vector positions
// ----------------------------------------------------------------
`define TTPF_PIN_IRC      5
`define TTPF_PIN_OSC      4
`define TTPF_PIN_FREF     3
`define TTPF_PIN_STOP     2
`define TTPF_PIN_LOCK     1
`define TTPF_PIN_OSCGOOD  0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TTPF_RST_TICK     8'h00
`define TTPF_RST_FM       2'h0
`define TTPF_RST_PLL_AS_SYSTEM_CLOCK_SEL   1'b1
`define TTPF_RST_MASK     2'h0

// ----------------------------------------------------------------
// divider constants
// ----------------------------------------------------------------
`define TTPF_BIN_SHIFT    5'h09
`define TTPF_DEC0         18'h003e8
`define TTPF_DEC1         18'h007d0
`define TTPF_DEC2         18'h01388
`define TTPF_DEC3         18'h02710
`define TTPF_DEC4         18'h04e20
`define TTPF_DEC5         18'h0c350
`define TTPF_DEC6         18'h186a0
`define TTPF_DEC7         18'h30d40
`define TTPF_FM_LAST      4'hf

`endif

// ---- rtl/ttpf_pkg.sv ----
package ttpf_pkg;
	typedef logic [7:0]  ttpf_byte_t;
	typedef logic [17:0] ttpf_cnt_t;
	typedef logic [11:0] ttpf_addr_t;
	typedef logic [31:0] ttpf_word_t;
	typedef logic [5:0]  ttpf_pins_t;
endpackage

// ---- rtl/ttpf_tick_if.sv ----
interface ttpf_tick_if;
	import ttpf_pkg::*;
	ttpf_byte_t cfg;
	logic       restart;
	logic       step;
	logic       tick;

	modport ctrl (output cfg, output restart, output step, input tick);
	modport div  (input cfg, input restart, input step, output tick);
endinterface

// ---- rtl/ttpf_tick_div.sv ----
`include "ttpf_defs.svh"

module ttpf_tick_div (
	// clock and reset
	input wire logic   clk_i,
	input wire logic   reset_i,
	// control side
	ttpf_tick_if.div   tif
);
	import ttpf_pkg::*;

	ttpf_cnt_t  pre_cnt;
	ttpf_cnt_t  next_pre_cnt;
	logic [3:0] mod_cnt;
	logic [3:0] next_mod_cnt;
	logic       tick;
	logic       next_tick;
	ttpf_cnt_t  limit;

	// ----------------------------------------------------------------
	// prescale length, zero means timer off
	// ----------------------------------------------------------------
	function automatic ttpf_cnt_t prescale_len(input ttpf_byte_t cfg);
		logic [2:0] code;
		code = cfg[`TTPF_PRE_HI:`TTPF_PRE_LO];
		prescale_len = '0;
		if (cfg[`TTPF_TICK_DEC]) begin
			unique case (code)
				3'h0: prescale_len = `TTPF_DEC0;
				3'h1: prescale_len = `TTPF_DEC1;
				3'h2: prescale_len = `TTPF_DEC2;
				3'h3: prescale_len = `TTPF_DEC3;
				3'h4: prescale_len = `TTPF_DEC4;
				3'h5: prescale_len = `TTPF_DEC5;
				3'h6: prescale_len = `TTPF_DEC6;
				3'h7: prescale_len = `TTPF_DEC7;
			endcase
		end else if (code != 3'h0) begin
			prescale_len = 18'h00001 << ({2'h0, code} + `TTPF_BIN_SHIFT);
		end
	endfunction

	// ----------------------------------------------------------------
	// prescaler and modulus counter
	// ----------------------------------------------------------------
	always_comb begin
		limit        = prescale_len(tif.cfg);
		next_pre_cnt = pre_cnt;
		next_mod_cnt = mod_cnt;
		next_tick    = 1'b0;
		if (tif.restart || limit == '0) begin
			next_pre_cnt = '0;
			next_mod_cnt = '0;
		end else if (tif.step) begin
			if (pre_cnt == limit - 18'h00001) begin
				next_pre_cnt = '0;
				if (mod_cnt == tif.cfg[`TTPF_MOD_HI:`TTPF_MOD_LO]) begin
					next_mod_cnt = '0;
					next_tick    = 1'b1;
				end else begin
					next_mod_cnt = mod_cnt + 4'h1;
				end
			end else begin
				next_pre_cnt = pre_cnt + 18'h00001;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pre_cnt <= '0;
			mod_cnt <= '0;
			tick    <= 1'b0;
		end else begin
			pre_cnt <= next_pre_cnt;
			mod_cnt <= next_mod_cnt;
			tick    <= next_tick;
		end
	end

	assign tif.tick = tick;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	restart_clears_a: assert property (@(posedge clk_i) disable iff (reset_i)
		tif.restart |=> (pre_cnt == '0 && mod_cnt == '0 && !tick))
		else $error("restart did not clear the tick counters");

	modulus_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
		tick |-> ($past(mod_cnt) == $past(tif.cfg[`TTPF_MOD_HI:`TTPF_MOD_LO])))
		else $error("tick raised before the modulus count ended");

	prescale_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
		tick |-> ($past(pre_cnt) == $past(limit) - 18'h00001 && $past(tif.step)))
		else $error("tick raised before the prescale count ended");

	timer_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(!tif.cfg[`TTPF_TICK_DEC] && tif.cfg[`TTPF_PRE_HI:`TTPF_PRE_LO] == 3'h0)
		|=> !tick)
		else $error("tick raised while the timer is off");
endmodule

// ---- testbench/test_ttpf_top.sv ----
`include "ttpf_defs.svh"

module test_ttpf_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ttpf_pkg::*;

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic        clk_i;
	logic        reset_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	ttpf_addr_t  paddr;
	ttpf_word_t  pwdata;
	ttpf_word_t  prdata;
	logic        pready;
	logic        pslverr;
	logic        irc;
	logic        osc;
	logic        fref;
	logic        stop;
	logic        lock;
	logic        osc_good;
	logic        irc_en;
	logic        osc_en;
	logic        irq;
	logic        tick;
	logic [1:0]  fm_amp;
	logic        fm_active;
	logic [3:0]  fm_phase;
	logic [1:0]  ph;
	ttpf_word_t  d;
	logic        e;
	logic [3:0]  p0;
	int          n;
	int          err_total;
	int          checked;

	ttpf_top dut (
		.CLK_I       (clk_i),
		.RESET_I     (reset_i),
		.PSEL_I      (psel),
		.PENABLE_I   (penable),
		.PWRITE_I    (pwrite),
		.PADDR_I     (paddr),
		.PWDATA_I    (pwdata),
		.PRDATA_O    (prdata),
		.PREADY_O    (pready),
		.PSLVERR_O   (pslverr),
		.IRC_CLK_I   (irc),
		.OSC_CLK_I   (osc),
		.FREF_I      (fref),
		.STOP_I      (stop),
		.PLL_LOCK_I  (lock),
		.OSC_GOOD_I  (osc_good),
		.IRQ_O       (irq),
		.TICK_O      (tick),
		.FM_AMP_O    (fm_amp),
		.FM_ACTIVE_O (fm_active),
		.FM_PHASE_O  (fm_phase)
	);

	// ----------------------------------------------------------------
	// clock and source clocks (one rising edge every two cycles)
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		ph <= ph + 2'h1;
		irc <= irc_en & ph[0];
		osc <= osc_en & ph[0];
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input ttpf_word_t seen, input ttpf_word_t exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic wr, input logic [7:0] idx, input ttpf_word_t wd,
			output ttpf_word_t rd, output logic er);
		int k;
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk_i);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk_i);
			if (pready === 1'b1) begin
				break;
			end
		end
		if (k == 16) begin
			err_total++;
			conclude();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input ttpf_word_t wd);
		ttpf_word_t r;
		logic x;
		xfer(1'b1, idx, wd, r, x);
	endtask

	task automatic rd_chk(input logic [7:0] idx, input ttpf_word_t exp);
		ttpf_word_t r;
		logic x;
		xfer(1'b0, idx, 32'h0, r, x);
		check(r, exp);
	endtask

	// counts cycles until a tick pulse; a must-wait that runs out ends the run
	task automatic wait_tick(input int lim, input logic must, output int cnt);
		cnt = 0;
		while (cnt < lim) begin
			@(negedge clk_i);
			if (tick === 1'b1) begin
				break;
			end
			cnt++;
		end
		if (must && cnt >= lim) begin
			err_total++;
			conclude();
		end
	endtask

	task automatic period(input ttpf_word_t cfg, output int cnt);
		wr(`TTPF_IDX_TICK, cfg);
		wait_tick(70000, 1'b1, cnt);
		wait_tick(70000, 1'b1, cnt);
	endtask

	task automatic pins_settle();
		repeat (8) @(posedge clk_i);
	endtask

	task automatic fref_edges(input int cnt);
		repeat (cnt) begin
			@(posedge clk_i);
			fref <= 1'b1;
			repeat (3) @(posedge clk_i);
			fref <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
		pins_settle();
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_i = 1'b1;
		{psel, penable, pwrite, fref, stop, lock, osc_good, osc_en} = '0;
		irc_en = 1'b1;
		{irc, osc, ph} = '0;
		paddr = '0;
		pwdata = '0;
		err_total = 0;
		checked = 0;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		// reset values and an unmapped place
		rd_chk(`TTPF_IDX_TICK, 32'h0);
		rd_chk(`TTPF_IDX_PLL, 32'h0);
		rd_chk(`TTPF_IDX_CLKSEL, 32'h80);
		rd_chk(`TTPF_IDX_STAT, 32'h0);
		xfer(1'b0, 8'h3c, 32'h0, d, e);
		check({31'h0, e}, 32'h1);
		check(d, 32'h0);
		wait_tick(5000, 1'b0, n);
		check(n, 32'd5000);
		// read and write at any time
		wr(`TTPF_IDX_TICK, 32'ha5);
		rd_chk(`TTPF_IDX_TICK, 32'ha5);
		// divide rates on the rc source
		wr(`TTPF_IDX_MASK, 32'h3);
		period(32'h10, n);
		check(n, 32'd2047);
		period(32'h11, n);
		check(n, 32'd4095);
		period(32'h20, n);
		check(n, 32'd4095);
		period(32'h80, n);
		check(n, 32'd1999);
		period(32'h81, n);
		check(n, 32'd3999);
		// tick event flag and interrupt
		pins_settle();
		rd_chk(`TTPF_IDX_STAT, 32'h1);
		@(negedge clk_i);
		check({31'h0, irq}, 32'h1);
		wr(`TTPF_IDX_MASK, 32'h0);
		@(negedge clk_i);
		check({31'h0, irq}, 32'h0);
		wr(`TTPF_IDX_STAT, 32'h1);
		rd_chk(`TTPF_IDX_STAT, 32'h0);
		// a write in mid-period restarts it
		period(32'h10, n);
		repeat (1000) @(posedge clk_i);
		wr(`TTPF_IDX_TICK, 32'h10);
		wait_tick(9000, 1'b1, n);
		check({31'h0, (n >= 2040 && n <= 2056)}, 32'h1);
		// stop halts the rc-sourced counter
		@(posedge clk_i);
		stop <= 1'b1;
		wait_tick(6000, 1'b0, n);
		check(n, 32'd6000);
		@(posedge clk_i);
		stop <= 1'b0;
		wait_tick(5000, 1'b1, n);
		// oscillator source keeps running in pseudo halt
		@(posedge clk_i);
		osc_good <= 1'b1;
		pins_settle();
		wr(`TTPF_IDX_CLKSEL, 32'hc2);
		rd_chk(`TTPF_IDX_CLKSEL, 32'hc2);
		irc_en <= 1'b0;
		osc_en <= 1'b1;
		stop <= 1'b1;
		wait_tick(9000, 1'b1, n);
		wait_tick(9000, 1'b1, n);
		check(n, 32'd2047);
		wr(`TTPF_IDX_CLKSEL, 32'h82);
		wait_tick(6000, 1'b0, n);
		check(n, 32'd6000);
		@(posedge clk_i);
		stop <= 1'b0;
		// losing the oscillator clears the source select and flags it
		wr(`TTPF_IDX_STAT, 32'h1);
		wr(`TTPF_IDX_MASK, 32'h2);
		osc_good <= 1'b0;
		pins_settle();
		rd_chk(`TTPF_IDX_CLKSEL, 32'h80);
		rd_chk(`TTPF_IDX_STAT, 32'h2);
		@(negedge clk_i);
		check({31'h0, irq}, 32'h1);
		wr(`TTPF_IDX_STAT, 32'h2);
		@(negedge clk_i);
		check({31'h0, irq}, 32'h0);
		// pll control: accepted write clears lock and oscillator-up flags
		@(posedge clk_i);
		osc_good <= 1'b1;
		lock <= 1'b1;
		pins_settle();
		rd_chk(`TTPF_IDX_STAT, 32'hc);
		wr(`TTPF_IDX_PLL, 32'h10);
		rd_chk(`TTPF_IDX_PLL, 32'h10);
		rd_chk(`TTPF_IDX_STAT, 32'h0);
		for (int c = 3; c >= 0; c--) begin
			wr(`TTPF_IDX_PLL, ttpf_word_t'(c) << 4);
			repeat (3) @(negedge clk_i);
			check({30'h0, fm_amp}, ttpf_word_t'(c));
			check({31'h0, fm_active}, {31'h0, c != 0});
		end
		// rejected writes: protection set, then pll clock not selected
		wr(`TTPF_IDX_WRITE_PROTECT_BIT, 32'h1);
		wr(`TTPF_IDX_PLL, 32'h20);
		rd_chk(`TTPF_IDX_PLL, 32'h0);
		wr(`TTPF_IDX_WRITE_PROTECT_BIT, 32'h0);
		wr(`TTPF_IDX_CLKSEL, 32'h00);
		wr(`TTPF_IDX_PLL, 32'h20);
		rd_chk(`TTPF_IDX_PLL, 32'h0);
		check({30'h0, fm_amp}, 32'h0);
		wr(`TTPF_IDX_CLKSEL, 32'h80);
		wr(`TTPF_IDX_PLL, 32'h30);
		// modulation phase wraps every sixteen reference edges
		repeat (3) @(negedge clk_i);
		p0 = fm_phase;
		fref_edges(4);
		@(negedge clk_i);
		check({28'h0, fm_phase}, {28'h0, p0 + 4'h4});
		fref_edges(12);
		@(negedge clk_i);
		check({28'h0, fm_phase}, {28'h0, p0});
		conclude();
	end

	// ----------------------------------------------------------------
	// overall bound on run length
	// ----------------------------------------------------------------
	initial begin
		repeat (99000) @(posedge clk_i);
		err_total++;
		conclude();
	end
endmodule
